//--- hw/process_alarm_dwell_timer.sv
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "alarm_defines.svh"
// Function
// - either channel dwell, both flags error
// - dwell time in tenths, up to 6553.5
// - dwell count starts at setpoint reach
// - dwell output holds until count expires
// - dwell ignores mode, level, hysteresis
// - eight absolute process alarm functions
// - either-value alarm on primary or secondary
// - difference alarm uses primary minus secondary
// - comparison uses level, never setpoint
// - thresholds at level plus minus half hysteresis
// - hysteresis defaults to one tenth
// - normal mode follows alarm condition
// - latching mode keeps output energized
// - latch released by reset or event input
// - holding suppresses until setpoint first reached
// - latch-hold combines holding and latching
module process_alarm_dwell_timer
  import alarm_pkg::*;
#(
  parameter int TICK_CYCLES = `DWELL_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire wb_req_s wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire process_in_s process_in,
  input wire logic event_input,
  output logic [1:0] alarm_out,
  output logic duplicate_dwell_error,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] apply_sel(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic signed [17:0] ext(input logic [15:0] v);
    return {{2{v[15]}}, v};
  endfunction

  // high sets above upper and clears below lower; low is the mirror
  function automatic logic hyst_step(input logic prev,
                                     input logic signed [17:0] val,
                                     input logic [15:0] lvl,
                                     input logic [15:0] hy,
                                     input logic high);
    logic signed [17:0] half;
    logic signed [17:0] upper;
    logic signed [17:0] lower;
    logic r;
    half = {3'h0, hy[15:1]};
    upper = ext(lvl) + half;
    lower = ext(lvl) - half;
    r = prev;
    if (high) begin
      if (val > upper) r = 1'b1;
      else if (val < lower) r = 1'b0;
    end else begin
      if (val < lower) r = 1'b1;
      else if (val > upper) r = 1'b0;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  state_s s;
  state_s n;
  alarm_fn_e fn0;
  alarm_fn_e fn1;
  alarm_mode_e mode0;
  logic both_dwell;
  logic latch_clear;

  assign fn0 = alarm_fn_e'(s.ctrl[`FN1_LSB +: 4]);
  assign fn1 = alarm_fn_e'(s.ctrl[`FN2_LSB +: 4]);
  assign mode0 = alarm_mode_e'(s.ctrl[`MODE1_LSB +: 2]);
  assign both_dwell = (fn0 == dwell_function_code) && (fn1 == dwell_function_code);
  assign latch_clear = event_input && s.ctrl[`LATCH_RESET_BIT];

  always_comb begin
    alarm_fn_e fn;
    alarm_mode_e mode;
    logic [15:0] lvl;
    logic [15:0] hy;
    logic [15:0] cnt;
    logic signed [17:0] va;
    logic signed [17:0] vb;
    logic signed [17:0] sp_diff;
    logic high;
    logic raw;
    logic eff;
    logic reach_now;
    logic tick_wrap;
    logic req;
    logic [3:0] ev;
    logic [3:0] clr;
    fn = alarm_off_function;
    mode = normal_alarm_mode;
    lvl = 16'h0000;
    hy = 16'h0000;
    cnt = 16'h0000;
    va = 18'sh0;
    vb = 18'sh0;
    high = 1'b0;
    raw = 1'b0;
    eff = 1'b0;
    ev = 4'h0;
    clr = 4'h0;
    sp_diff = 18'sh0;
    reach_now = 1'b0;
    tick_wrap = 1'b0;
    n = s;
    req = wb_req.cyc && wb_req.stb && !s.ack;

    // setpoint reach: first touch or crossing since reset, any active setpoint
    sp_diff = ext(process_in.primary_process_value) - ext(process_in.active_setpoint);
    n.seen = 1'b1;
    if (!s.seen) begin
      n.start_below = sp_diff < 0;
    end
    reach_now = !s.reached && s.seen
                && ((sp_diff == 0) || ((sp_diff < 0) != s.start_below));
    if (reach_now) begin
      n.reached = 1'b1;
    end

    // one shared tenth-minute prescaler; only one channel may be dwelling
    tick_wrap = s.tick == 32'(TICK_CYCLES - 1);
    if (reach_now || !s.reached || tick_wrap) begin
      n.tick = 32'h0000_0000;
    end else begin
      n.tick = s.tick + 32'h0000_0001;
    end

    n.err = both_dwell;

    for (int i = 0; i < 2; i++) begin
      fn = alarm_fn_e'(s.ctrl[(i == 0 ? `FN1_LSB : `FN2_LSB) +: 4]);
      mode = alarm_mode_e'(s.ctrl[(i == 0 ? `MODE1_LSB : `MODE2_LSB) +: 2]);
      lvl = (i == 0) ? s.level1 : s.level2;
      hy = (i == 0) ? s.hyst1 : s.hyst2;
      cnt = (i == 0) ? s.count1 : s.count2;
      if (fn <= difference_low_function) begin
        high = !fn[0];
        unique case (fn)
          primary_high_function, primary_low_function,
          either_high_function, either_low_function: begin
            va = ext(process_in.primary_process_value);
          end
          secondary_high_function, secondary_low_function: begin
            va = ext(process_in.secondary_process_value);
          end
          default: begin
            va = ext(process_in.primary_process_value)
                 - ext(process_in.secondary_process_value);
          end
        endcase
        vb = ext(process_in.secondary_process_value);
        // only the level and hysteresis registers feed the compare
        n.cond_a[i] = hyst_step(s.cond_a[i], va, lvl, hy, high);
        n.cond_b[i] = hyst_step(s.cond_b[i], vb, lvl, hy, high);
        raw = (fn == either_high_function || fn == either_low_function)
              ? (n.cond_a[i] || n.cond_b[i]) : n.cond_a[i];
        eff = raw;
        if (mode == holding_alarm_mode || mode == latch_hold_alarm_mode) begin
          eff = raw && n.reached;
        end
        if (mode == latching_alarm_mode || mode == latch_hold_alarm_mode) begin
          n.out[i] = eff || (s.out[i] && !latch_clear);
        end else begin
          n.out[i] = eff;
        end
        n.done[i] = 1'b0;
        cnt = 16'h0000;
      end else if (fn == dwell_function_code && !both_dwell) begin
        // mode, level and hysteresis unused here
        n.cond_a[i] = 1'b0;
        n.cond_b[i] = 1'b0;
        if (reach_now) begin
          cnt = 16'h0000;
          n.done[i] = 1'b0;
        end else if (s.reached && !s.done[i] && cnt == s.dwell) begin
          n.done[i] = 1'b1;
        end else if (s.reached && !s.done[i] && tick_wrap) begin
          cnt = cnt + 16'h0001;
        end
        n.out[i] = n.done[i] ? 1'b1 : s.out[i];
        ev[`IRQ_DWELL_BIT] = ev[`IRQ_DWELL_BIT] | (n.done[i] & !s.done[i]);
      end else begin
        n.cond_a[i] = 1'b0;
        n.cond_b[i] = 1'b0;
        n.out[i] = 1'b0;
        n.done[i] = 1'b0;
        cnt = 16'h0000;
      end
      if (i == 0) begin
        n.count1 = cnt;
      end else begin
        n.count2 = cnt;
      end
    end

    ev[`IRQ_ALARM1_BIT] = n.out[0] && !s.out[0];
    ev[`IRQ_ALARM2_BIT] = n.out[1] && !s.out[1];
    ev[`IRQ_ERROR_BIT] = n.err && !s.err;

    //////////////////////////////////////////////////////////////////////////
    // classic wishbone slave, one wait state, unmapped reads return zero
    n.ack = req;
    n.rdata = 32'h0000_0000;
    if (req && wb_req.we) begin
      unique case (wb_req.adr)
        `CTRL_OFFSET: n.ctrl = apply_sel(s.ctrl, wb_req.dat, wb_req.sel);
        `LEVEL1_OFFSET: n.level1 = 16'(apply_sel({16'h0000, s.level1}, wb_req.dat, wb_req.sel));
        `LEVEL2_OFFSET: n.level2 = 16'(apply_sel({16'h0000, s.level2}, wb_req.dat, wb_req.sel));
        `HYST1_OFFSET: n.hyst1 = 16'(apply_sel({16'h0000, s.hyst1}, wb_req.dat, wb_req.sel));
        `HYST2_OFFSET: n.hyst2 = 16'(apply_sel({16'h0000, s.hyst2}, wb_req.dat, wb_req.sel));
        // full 16-bit range is 0 to 6553.5 minutes
        `DWELL_OFFSET: n.dwell = 16'(apply_sel({16'h0000, s.dwell}, wb_req.dat, wb_req.sel));
        `IRQ_MASK_OFFSET: n.irq_mask = 4'(apply_sel({28'h0, s.irq_mask}, wb_req.dat, wb_req.sel));
        default: n.ctrl = s.ctrl;
      endcase
    end else if (req) begin
      unique case (wb_req.adr)
        `CTRL_OFFSET: n.rdata = s.ctrl & 32'h0001_3F3F;
        `LEVEL1_OFFSET: n.rdata = {16'h0000, s.level1};
        `LEVEL2_OFFSET: n.rdata = {16'h0000, s.level2};
        `HYST1_OFFSET: n.rdata = {16'h0000, s.hyst1};
        `HYST2_OFFSET: n.rdata = {16'h0000, s.hyst2};
        `DWELL_OFFSET: n.rdata = {16'h0000, s.dwell};
        `STATE_OFFSET: n.rdata = {26'h0, s.reached, s.err, s.done, s.out};
        `IRQ_STATUS_OFFSET: begin
          n.rdata = {28'h0, s.irq_st};
          clr = 4'hF;
        end
        `IRQ_MASK_OFFSET: n.rdata = {28'h0, s.irq_mask};
        `COUNT1_OFFSET: n.rdata = {16'h0000, s.count1};
        `COUNT2_OFFSET: n.rdata = {16'h0000, s.count2};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    // an event in the clearing read's cycle survives it
    n.irq_st = (s.irq_st & ~clr) | ev;
    n.irq = |(n.irq_st & n.irq_mask);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.ctrl <= `CTRL_RESET;
      s.level1 <= `LEVEL_RESET;
      s.level2 <= `LEVEL_RESET;
      s.hyst1 <= `HYST_RESET;
      s.hyst2 <= `HYST_RESET;
      s.dwell <= `DWELL_RESET;
    end else begin
      s <= n;
    end
  end

  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign alarm_out = s.out;
  assign duplicate_dwell_error = s.err;
  assign irq = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_dup_error;
    both_dwell |=> duplicate_dwell_error && alarm_out == 2'b00;
  endproperty
  a_dup_error: assert property (p_dup_error) else $error("dual dwell not flagged");

  property p_dwell_hold;
    (fn0 == dwell_function_code && !both_dwell && !s.done[0] && $stable(s.ctrl))
      ##1 !s.done[0] |-> $stable(alarm_out[0]);
  endproperty
  a_dwell_hold: assert property (p_dwell_hold) else $error("dwell output moved early");

  property p_dwell_start;
    (fn0 == dwell_function_code && !both_dwell && $rose(s.reached))
      |-> s.count1 == 16'h0000 && !s.done[0];
  endproperty
  a_dwell_start: assert property (p_dwell_start) else $error("dwell count not zero at start");

  property p_dwell_bound;
    // a new duration written mid-count may sit below the count
    (fn0 == dwell_function_code && s.count1 <= s.dwell)
      ##1 $stable(s.dwell) |-> s.count1 <= s.dwell;
  endproperty
  a_dwell_bound: assert property (p_dwell_bound) else $error("dwell count overran");

  property p_normal;
    ($stable(s.ctrl) && mode0 == normal_alarm_mode && fn0 <= difference_low_function)
      |-> alarm_out[0] == ((fn0 == either_high_function || fn0 == either_low_function)
                           ? (s.cond_a[0] | s.cond_b[0]) : s.cond_a[0]);
  endproperty
  a_normal: assert property (p_normal) else $error("normal output not following alarm");

  property p_latch_keep;
    ($stable(s.ctrl) && fn0 <= difference_low_function && alarm_out[0] && !latch_clear
     && (mode0 == latching_alarm_mode || mode0 == latch_hold_alarm_mode)) |=> alarm_out[0];
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latched alarm dropped");

  property p_latch_release;
    ($stable(s.ctrl) && (mode0 == latching_alarm_mode) && $fell(alarm_out[0]))
      |-> $past(latch_clear);
  endproperty
  a_latch_release: assert property (p_latch_release) else $error("latch released no event");

  property p_holding;
    ((mode0 == holding_alarm_mode || mode0 == latch_hold_alarm_mode)
     && fn0 <= difference_low_function && !s.reached && $stable(s.ctrl))
      ##1 !s.reached |-> !alarm_out[0];
  endproperty
  a_holding: assert property (p_holding) else $error("alarm before setpoint reach");

  property p_high_trip;
    (fn0 == primary_high_function && $stable(s.ctrl) && $stable(s.level1) && $stable(s.hyst1)
     && ext(process_in.primary_process_value) > ext(s.level1) + $signed({3'h0, s.hyst1[15:1]}))
      |=> s.cond_a[0];
  endproperty
  a_high_trip: assert property (p_high_trip) else $error("high alarm did not set");

  c_dwell_expire: cover property (fn0 == dwell_function_code ##1 $rose(s.done[0]));
  c_latch_clear: cover property (mode0 == latching_alarm_mode && alarm_out[0] ##1 !alarm_out[0]);
  c_irq: cover property ($rose(irq));

endmodule

//--- hw/alarm_defines.svh
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH

// register byte offsets
`define CTRL_OFFSET 8'h00
`define LEVEL1_OFFSET 8'h04
`define LEVEL2_OFFSET 8'h08
`define HYST1_OFFSET 8'h0C
`define HYST2_OFFSET 8'h10
`define DWELL_OFFSET 8'h14
`define STATE_OFFSET 8'h18
`define IRQ_STATUS_OFFSET 8'h1C
`define IRQ_MASK_OFFSET 8'h20
`define COUNT1_OFFSET 8'h24
`define COUNT2_OFFSET 8'h28

// control register fields
`define FN1_LSB 0
`define MODE1_LSB 4
`define FN2_LSB 8
`define MODE2_LSB 12
`define LATCH_RESET_BIT 16

// reset values; both channels start with alarm off
`define CTRL_RESET 32'h0000_0909
`define LEVEL_RESET 16'h0000
`define HYST_RESET 16'h0001
`define DWELL_RESET 16'h0000
`define DWELL_MAX_TENTHS 16'hFFFF

// interrupt status bits
`define IRQ_ALARM1_BIT 0
`define IRQ_ALARM2_BIT 1
`define IRQ_DWELL_BIT 2
`define IRQ_ERROR_BIT 3

// dwell resolution is a tenth of a minute
`define DWELL_TICK_MS 6000
`define CLK_KHZ 25000
`define DWELL_TICK_CYCLES (`DWELL_TICK_MS * `CLK_KHZ)

`endif

//--- hw/alarm_pkg.sv
package alarm_pkg;

  typedef enum logic [3:0] {
    primary_high_function,
    primary_low_function,
    secondary_high_function,
    secondary_low_function,
    either_high_function,
    either_low_function,
    difference_high_function,
    difference_low_function,
    dwell_function_code,
    alarm_off_function
  } alarm_fn_e;

  typedef enum logic [1:0] {
    normal_alarm_mode,
    latching_alarm_mode,
    holding_alarm_mode,
    latch_hold_alarm_mode
  } alarm_mode_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic [15:0] primary_process_value;
    logic [15:0] secondary_process_value;
    logic [15:0] active_setpoint;
  } process_in_s;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] level1;
    logic [15:0] level2;
    logic [15:0] hyst1;
    logic [15:0] hyst2;
    logic [15:0] dwell;
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] cond_a;
    logic [1:0] cond_b;
    logic [1:0] out;
    logic [1:0] done;
    logic [15:0] count1;
    logic [15:0] count2;
    logic [31:0] tick;
    logic seen;
    logic start_below;
    logic reached;
    logic err;
    logic irq;
  } state_s;

endpackage

//--- bench/alarm_relay_model.sv
`timescale 1ns/1ps
// relay pair switched by the alarm outputs; contacts lag the coil drive
module alarm_relay_model #(
  parameter int DELAY = 3
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [1:0] coil,
  output logic [1:0] contact
);
  logic [1:0] pipe [DELAY];
  // mechanical pickup and drop-out both take DELAY cycles
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DELAY; i++) pipe[i] <= 2'h0;
    end else begin
      pipe[0] <= coil;
      for (int i = 1; i < DELAY; i++) pipe[i] <= pipe[i-1];
    end
  end
  assign contact = pipe[DELAY-1];
endmodule

//--- bench/process_alarm_dwell_timer_tb.sv
`timescale 1ns/1ps
`include "alarm_defines.svh"
module process_alarm_dwell_timer_tb;
  import alarm_pkg::*;
  logic sys_clk, arst_n, event_input, dup_err, irq;
  wb_req_s wb_req;
  process_in_s process_in;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o;
  logic [1:0] alarm_out, contact;
  int errors, checks_done, lv[2], hy[2], p, s;
  logic ca[2], cb[2], ex[2];
  process_alarm_dwell_timer #(.TICK_CYCLES(4)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
    .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .process_in(process_in),
    .event_input(event_input), .alarm_out(alarm_out), .duplicate_dwell_error(dup_err),
    .irq(irq));
  alarm_relay_model relays (.sys_clk(sys_clk), .arst_n(arst_n), .coil(alarm_out),
    .contact(contact));
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // classic cycle: hold until ack sampled high, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge sys_clk);
    wb_req <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic drive(input int pv, input int sv, input int sp, input int n);
    @(posedge sys_clk);
    process_in <= '{pv[15:0], sv[15:0], sp[15:0]};
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
  endtask
  // hysteresis band around the level, half the band on each side
  function automatic logic upd(logic c, int v, int l, int h, logic high);
    if (v > l + h / 2) return high;
    if (v < l - h / 2) return !high;
    return c;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    wrap_up();
  end
  initial begin
    arst_n = 0;
    event_input = 0;
    wb_req = '0;
    process_in = '{16'h0000, 16'h0000, 16'h7FFF};
    errors = 0;
    checks_done = 0;
    void'($urandom(41979));
    do_reset();
    wb(0, `CTRL_OFFSET, 0);
    check(rd, `CTRL_RESET);
    wb(0, `HYST1_OFFSET, 0);
    check(rd, 32'h0000_0001);
    wb(0, 8'h40, 0);
    check(rd, 32'h0);
    // all eight process functions on both channels, random levels and values
    for (int f = 0; f < 8; f++) begin
      for (int c = 0; c < 2; c++) begin
        lv[c] = $urandom_range(400) - 200;
        hy[c] = $urandom_range(40, 1);
        ca[c] = 0;
        cb[c] = 0;
        wb(1, c ? `LEVEL2_OFFSET : `LEVEL1_OFFSET, {16'h0, lv[c][15:0]});
        wb(1, c ? `HYST2_OFFSET : `HYST1_OFFSET, {16'h0, hy[c][15:0]});
      end
      p = f[0] ? 2000 : -2000;
      s = f >= 6 ? -p : p;
      drive(p, s, 32767, 2);
      wb(1, `CTRL_OFFSET, {20'h0, f[3:0], 4'h0, f[3:0]});
      drive(p, s, 32767, 4);
      for (int k = 0; k < 10; k++) begin
        p = $urandom_range(2000) - 1000;
        s = (k == 0) ? p : $urandom_range(2000) - 1000;
        drive(p, s, 32767, 4);
        for (int c = 0; c < 2; c++) begin
          case (f / 2)
            0: ca[c] = upd(ca[c], p, lv[c], hy[c], !f[0]);
            1: ca[c] = upd(ca[c], s, lv[c], hy[c], !f[0]);
            2: begin
              ca[c] = upd(ca[c], p, lv[c], hy[c], !f[0]);
              cb[c] = upd(cb[c], s, lv[c], hy[c], !f[0]);
            end
            default: ca[c] = upd(ca[c], p - s, lv[c], hy[c], !f[0]);
          endcase
          ex[c] = ca[c] | cb[c];
        end
        check(alarm_out, {ex[1], ex[0]});
      end
    end
    repeat (4) @(posedge sys_clk);
    check(contact, {ex[1], ex[0]});
    // latching, holding and latch-hold, each from a fresh power-up
    for (int m = 1; m < 4; m++) begin
      do_reset();
      check(alarm_out, 2'b00);
      drive(0, 0, 500, 3);
      wb(1, `LEVEL1_OFFSET, 32'd100);
      wb(1, `IRQ_MASK_OFFSET, 32'h1);
      wb(1, `CTRL_OFFSET, {18'h0, 2'h0, 4'h9, 2'h0, m[1:0], 4'h0});
      drive(300, 0, 500, 4);
      check(alarm_out[0], m == 1);
      drive(600, 0, 500, 4);
      check(alarm_out[0], 1'b1);
      check(irq, 1'b1);
      wb(0, `IRQ_STATUS_OFFSET, 0);
      check(rd[0], 1'b1);
      check(irq, 1'b0);
      drive(50, 0, 500, 4);
      check(alarm_out[0], m != 2);
      wb(1, `CTRL_OFFSET, {15'h0, 1'b1, 4'h0, 4'h9, 2'h0, m[1:0], 4'h0});
      event_input <= 1'b1;
      drive(50, 0, 500, 4);
      check(alarm_out[0], 1'b0);
      event_input <= 1'b0;
    end
    // dwell on channel one; mode and level settings must not matter
    do_reset();
    drive(0, 0, 50, 3);
    wb(1, `DWELL_OFFSET, 32'd3);
    wb(1, `LEVEL1_OFFSET, 32'hFF00);
    wb(1, `CTRL_OFFSET, {16'h0, 4'h0, 4'h9, 2'h0, 2'h3, 4'h8});
    drive(60, 0, 50, 6);
    check(alarm_out, 2'b00);
    repeat (30) @(posedge sys_clk);
    check(alarm_out, 2'b01);
    wb(0, `COUNT1_OFFSET, 0);
    check(rd, 32'd3);
    wb(0, `IRQ_STATUS_OFFSET, 0);
    check(rd, 32'h0000_0005);
    check(dup_err, 1'b0);
    wb(1, `CTRL_OFFSET, {16'h0, 4'h0, 4'h8, 4'h0, 4'h8});
    repeat (3) @(posedge sys_clk);
    check(dup_err, 1'b1);
    check(alarm_out, 2'b00);
    wb(0, `IRQ_STATUS_OFFSET, 0);
    check(rd, 32'h0000_0008);
    wb(0, `STATE_OFFSET, 0);
    check(rd, 32'h0000_0030);
    wrap_up();
  end
endmodule
